// *** pkg/clk_sel_consts.svh ***
`ifndef CLK_SEL_CONSTS_SVH
`define CLK_SEL_CONSTS_SVH

// ****************************************
// clock configuration encodings
// ****************************************
`define CFG_X4 3'h7
`define CFG_X3 3'h6
`define CFG_X8 3'h5
`define CFG_X5 3'h4
`define CFG_DIRECT 3'h3
`define CFG_X10 3'h2
`define CFG_PRESCALE 3'h1
`define CFG_X16 3'h0
`define CFG_RESET 3'h7

// ****************************************
// system configuration register field
// ****************************************
`define SYSCFG_OWD_DIS_BIT 4

// ****************************************
// timing counts
// ****************************************
`define SYNC_FILL_CYCLES 2'h2
`define OWD_OVERFLOW_TICKS 5'h10
`define PLL_FREE_DIV 4'h4
`define PERIOD_WIDTH 16

`endif

// *** pkg/clk_sel_pkg.sv ***
package clk_sel_pkg;

  typedef enum logic [1:0] {
    MODE_PLL = 2'b00,
    MODE_PRESCALE = 2'b01,
    MODE_DIRECT = 2'b10
  } clk_mode_t;

  typedef enum logic [1:0] {
    CAP_WAIT = 2'b00,
    CAP_FILL = 2'b01,
    CAP_HELD = 2'b10
  } cap_state_t;

endpackage : clk_sel_pkg

// *** verilog/pin_sync.sv ***
module pin_sync #(
  parameter int WIDTH = 4
) (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  // ****************************************
  // two-stage synchroniser per bit
  // ****************************************
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
          meta[i] <= 1'b0;
          sync_out[i] <= 1'b0;
        end else begin
          meta[i] <= async_in[i];
          sync_out[i] <= meta[i];
        end
      end
    end
  endgenerate

endmodule : pin_sync

// *** verilog/cpu_clock_source_select.sv ***
`include "clk_sel_consts.svh"

module cpu_clock_source_select (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic [2:0] clock_config_pins_in,
  input wire logic crystal_input_pin_in,
  input wire logic [15:0] system_config_reg_in,
  input wire logic sw_reset_in,
  output logic cpu_clock_out,
  output logic cpu_clock_rise_out,
  output logic cpu_clock_fall_out,
  output logic [2:0] clock_config_bits_out,
  output logic config_valid_out,
  output logic pll_enable_out,
  output logic osc_amp_enable_out,
  output logic osc_watchdog_fail_out,
  output logic osc_watchdog_irq_out
);

  logic [3:0] pins_sync;
  logic xtal_s;
  logic xtal_d;
  clk_sel_pkg::cap_state_t cap_state;
  logic [1:0] fill_cnt;
  logic [`PERIOD_WIDTH-1:0] period_cnt;
  logic [`PERIOD_WIDTH-1:0] period_last;
  logic [`PERIOD_WIDTH-1:0] phase_acc;
  logic [3:0] pll_div;
  logic [4:0] wd_cnt;

  // ****************************************
  // pin synchronisation
  // ****************************************
  pin_sync #(.WIDTH(4)) u_pin_sync (
    .clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in),
    .async_in({crystal_input_pin_in, clock_config_pins_in}),
    .sync_out(pins_sync)
  );

  // ****************************************
  // decode
  // ****************************************
  wire xtal_in_s = pins_sync[3];
  wire captured = (cap_state == clk_sel_pkg::CAP_HELD);
  wire [2:0] cfg = clock_config_bits_out;
  wire [5:0] mult = (cfg == `CFG_X4) ? 6'h04 :
                    (cfg == `CFG_X3) ? 6'h03 :
                    (cfg == `CFG_X8) ? 6'h08 :
                    (cfg == `CFG_X5) ? 6'h05 :
                    (cfg == `CFG_X10) ? 6'h0a :
                    (cfg == `CFG_X16) ? 6'h10 : 6'h01;
  wire clk_sel_pkg::clk_mode_t mode = clk_sel_pkg::clk_mode_t'(
    (cfg == `CFG_DIRECT) ? clk_sel_pkg::MODE_DIRECT :
    (cfg == `CFG_PRESCALE) ? clk_sel_pkg::MODE_PRESCALE :
    clk_sel_pkg::MODE_PLL);
  wire non_pll_mode = (mode != clk_sel_pkg::MODE_PLL);
  wire owd_disable = system_config_reg_in[`SYSCFG_OWD_DIS_BIT];
  wire wd_on = captured && non_pll_mode && !owd_disable;
  wire next_pll_enable = captured && (!non_pll_mode || !owd_disable);
  wire next_amp_enable = captured && (mode != clk_sel_pkg::MODE_DIRECT);
  wire xtal_rise = xtal_s && !xtal_d;
  wire xtal_edge = xtal_s ^ xtal_d;

  // ****************************************
  // pll model: free-running tick and multiplier
  // ****************************************
  wire pll_tick = (pll_div == `PLL_FREE_DIV - 4'h1);
  wire [`PERIOD_WIDTH-1:0] acc_sum = phase_acc + {{(`PERIOD_WIDTH-7){1'b0}}, mult, 1'b0};
  wire pll_toggle = (period_last != '0) && (acc_sum >= period_last);
  wire [`PERIOD_WIDTH-1:0] next_acc = pll_toggle ? acc_sum - period_last : acc_sum;

  // ****************************************
  // watchdog overflow
  // ****************************************
  wire wd_overflow = wd_on && pll_tick && !xtal_edge &&
                     (wd_cnt == `OWD_OVERFLOW_TICKS - 5'h01);
  // an overflow in the same cycle as a software reset still trips
  wire next_fail = wd_overflow || (!sw_reset_in && osc_watchdog_fail_out);

  // ****************************************
  // cpu clock selection
  // ****************************************
  wire next_cpu_clock =
    !captured ? 1'b0 :
    osc_watchdog_fail_out ? (pll_tick ? !cpu_clock_out : cpu_clock_out) :
    (mode == clk_sel_pkg::MODE_DIRECT) ? xtal_s :
    (mode == clk_sel_pkg::MODE_PRESCALE) ? (xtal_rise ^ cpu_clock_out) :
    (pll_toggle ^ cpu_clock_out);

  // ****************************************
  // configuration capture
  // ****************************************
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cap_state <= clk_sel_pkg::CAP_WAIT;
      fill_cnt <= 2'h0;
      clock_config_bits_out <= `CFG_RESET;
      config_valid_out <= 1'b0;
    end else begin
      case (cap_state)
        clk_sel_pkg::CAP_WAIT: begin
          cap_state <= clk_sel_pkg::CAP_FILL;
          fill_cnt <= 2'h0;
        end
        clk_sel_pkg::CAP_FILL: begin
          fill_cnt <= fill_cnt + 2'h1;
          if (fill_cnt == `SYNC_FILL_CYCLES - 2'h1) begin
            cap_state <= clk_sel_pkg::CAP_HELD;
            clock_config_bits_out <= pins_sync[2:0];
            config_valid_out <= 1'b1;
          end
        end
        clk_sel_pkg::CAP_HELD: begin
          cap_state <= clk_sel_pkg::CAP_HELD;
        end
        default: begin
          cap_state <= clk_sel_pkg::CAP_WAIT;
        end
      endcase
    end
  end

  // ****************************************
  // input clock measurement and pll model
  // ****************************************
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      xtal_s <= 1'b0;
      xtal_d <= 1'b0;
      period_cnt <= '0;
      period_last <= '0;
      phase_acc <= '0;
      pll_div <= 4'h0;
    end else begin
      xtal_s <= xtal_in_s;
      xtal_d <= xtal_s;
      period_cnt <= xtal_rise ? {{(`PERIOD_WIDTH-1){1'b0}}, 1'b1} : period_cnt + 1'b1;
      if (xtal_rise) begin
        period_last <= period_cnt;
      end
      phase_acc <= next_acc;
      pll_div <= pll_tick ? 4'h0 : pll_div + 4'h1;
    end
  end

  // ****************************************
  // watchdog and outputs
  // ****************************************
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wd_cnt <= 5'h00;
      osc_watchdog_fail_out <= 1'b0;
      osc_watchdog_irq_out <= 1'b0;
      cpu_clock_out <= 1'b0;
      cpu_clock_rise_out <= 1'b0;
      cpu_clock_fall_out <= 1'b0;
      pll_enable_out <= 1'b0;
      osc_amp_enable_out <= 1'b0;
    end else begin
      if (!wd_on || xtal_edge) begin
        wd_cnt <= 5'h00;
      end else if (pll_tick && wd_cnt != `OWD_OVERFLOW_TICKS) begin
        wd_cnt <= wd_cnt + 5'h01;
      end
      osc_watchdog_fail_out <= next_fail;
      osc_watchdog_irq_out <= next_fail && !osc_watchdog_fail_out;
      cpu_clock_out <= next_cpu_clock;
      cpu_clock_rise_out <= next_cpu_clock && !cpu_clock_out;
      cpu_clock_fall_out <= !next_cpu_clock && cpu_clock_out;
      pll_enable_out <= next_pll_enable || next_fail;
      osc_amp_enable_out <= next_amp_enable;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  a_config_held_stable: assert property (
    @(posedge clk_sys_in) disable iff (!reset_n_in)
    captured |=> $stable(clock_config_bits_out) && captured)
    else $error("clock configuration changed after capture");

  a_capture_from_pins: assert property (
    @(posedge clk_sys_in) disable iff (!reset_n_in)
    $rose(config_valid_out) |-> clock_config_bits_out == $past(pins_sync[2:0]))
    else $error("captured configuration differs from pins");

  a_decode_factor: assert property (
    @(posedge clk_sys_in) disable iff (!reset_n_in)
    captured |-> (cfg == `CFG_X16 ? mult == 6'h10 :
                  cfg == `CFG_X10 ? mult == 6'h0a :
                  cfg == `CFG_X8 ? mult == 6'h08 :
                  cfg == `CFG_X5 ? mult == 6'h05 :
                  cfg == `CFG_X4 ? mult == 6'h04 :
                  cfg == `CFG_X3 ? mult == 6'h03 : mult == 6'h01))
    else $error("multiplier decode wrong");

  a_prescale_phase_len: assert property (
    @(posedge clk_sys_in) disable iff (!reset_n_in)
    captured && mode == clk_sel_pkg::MODE_PRESCALE && !osc_watchdog_fail_out && !next_fail
    |=> cpu_clock_out == ($past(cpu_clock_out) ^ $past(xtal_rise)))
    else $error("prescaler phase not one input period");

  a_direct_follow_pin: assert property (
    @(posedge clk_sys_in) disable iff (!reset_n_in)
    captured && mode == clk_sel_pkg::MODE_DIRECT && !osc_watchdog_fail_out
    |=> cpu_clock_out == $past(xtal_s))
    else $error("direct drive clock does not follow pin");

  a_pll_off_disabled: assert property (
    @(posedge clk_sys_in) disable iff (!reset_n_in)
    captured && non_pll_mode && owd_disable && !osc_watchdog_fail_out && !next_fail
    |=> !pll_enable_out)
    else $error("pll running while watchdog disabled");

  a_amp_direct_off: assert property (
    @(posedge clk_sys_in) disable iff (!reset_n_in)
    captured ##1 captured |-> osc_amp_enable_out == ($past(mode) != clk_sel_pkg::MODE_DIRECT))
    else $error("oscillator amplifier enable wrong");

  a_wdog_overflow_trip: assert property (
    @(posedge clk_sys_in) disable iff (!reset_n_in)
    wd_overflow && !sw_reset_in |=> osc_watchdog_fail_out &&
    (osc_watchdog_irq_out == !$past(osc_watchdog_fail_out)))
    else $error("watchdog overflow did not trip");

  a_fail_sticky_hold: assert property (
    @(posedge clk_sys_in) disable iff (!reset_n_in)
    osc_watchdog_fail_out && !sw_reset_in |=> osc_watchdog_fail_out)
    else $error("watchdog fail released without reset");

  a_edge_pulse_match: assert property (
    @(posedge clk_sys_in) disable iff (!reset_n_in)
    ##1 (cpu_clock_rise_out == (cpu_clock_out && !$past(cpu_clock_out)) &&
         cpu_clock_fall_out == (!cpu_clock_out && $past(cpu_clock_out))))
    else $error("edge pulse does not match cpu clock");

endmodule : cpu_clock_source_select

// *** verif/xtal_source.sv ***
// ****************************************
// crystal or external clock source model
// ****************************************
module xtal_source (
  input wire logic clk_sys_in,
  input wire logic stop_in,
  input wire logic [7:0] half_hi_in,
  input wire logic [7:0] half_lo_in,
  output logic xtal_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] count = 8'h00;
  initial xtal_out = 1'b0;
  // a failed source freezes at its last level
  always @(posedge clk_sys_in) begin
    if (!stop_in) begin
      if (count + 8'h01 >= (xtal_out ? half_hi_in : half_lo_in)) begin
        count <= 8'h00;
        xtal_out <= ~xtal_out;
      end else begin
        count <= count + 8'h01;
      end
    end
  end
endmodule : xtal_source

// *** verif/tb.sv ***
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_in = 1'b0, reset_n_in = 1'b0, sw_reset_in = 1'b0, stop = 1'b0;
  logic [2:0] pins = 3'h7;
  logic [15:0] syscfg = 16'h0000;
  logic [7:0] hi = 8'h10, lo = 8'h10, seed = 8'h39;
  logic xtal, cpu, rise, fall, valid, pll_en, amp_en, fail, irq;
  logic [2:0] bits;
  int error_cnt = 0, comparisons = 0;
  always #4 clk_sys_in = ~clk_sys_in;
  xtal_source u_xtal_source (.clk_sys_in(clk_sys_in), .stop_in(stop), .half_hi_in(hi),
    .half_lo_in(lo), .xtal_out(xtal));
  cpu_clock_source_select u_cpu_clock_source_select (.clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in), .clock_config_pins_in(pins), .crystal_input_pin_in(xtal),
    .system_config_reg_in(syscfg), .sw_reset_in(sw_reset_in), .cpu_clock_out(cpu),
    .cpu_clock_rise_out(rise), .cpu_clock_fall_out(fall), .clock_config_bits_out(bits),
    .config_valid_out(valid), .pll_enable_out(pll_en), .osc_amp_enable_out(amp_en),
    .osc_watchdog_fail_out(fail), .osc_watchdog_irq_out(irq));
  // ****************************************
  // expectation helpers
  // ****************************************
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  function automatic int factor(input logic [2:0] c);
    case (c)
      3'h7: return 4;
      3'h6: return 3;
      3'h5: return 8;
      3'h4: return 5;
      3'h2: return 10;
      3'h0: return 16;
      default: return 0;
    endcase
  endfunction : factor
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results
  // sel 0 rise, 1 fall, 2 irq; n counts edges until the pulse
  task automatic wait_for(input int sel, input int bound, output int n);
    logic got;
    n = 0;
    got = 1'b0;
    while (!got && n < bound) begin
      @(posedge clk_sys_in);
      n++;
      got = (sel == 0) ? rise === 1'b1 : (sel == 1) ? fall === 1'b1 : irq === 1'b1;
    end
    if (!got) begin
      check("pulse wait", got, 1'b1);
      results();
    end
  endtask : wait_for
  task automatic meas(output int h, output int l);
    int n;
    wait_for(0, 300, n);
    check("cpu high at rise", cpu, 1'b1);
    wait_for(1, 300, h);
    check("cpu low at fall", cpu, 1'b0);
    wait_for(0, 300, l);
  endtask : meas
  task automatic start(input logic [2:0] c, input logic dis);
    @(posedge clk_sys_in);
    seed = lfsr(seed);
    reset_n_in <= 1'b0;
    pins <= c;
    syscfg <= {seed, seed} & 16'hffef | {11'h000, dis, 4'h0};
    repeat (4) @(posedge clk_sys_in);
    check("config during reset", {valid, bits}, 4'h7);
    reset_n_in <= 1'b1;
    repeat (6) @(posedge clk_sys_in);
    check("captured config", {valid, bits}, {1'b1, c});
    check("amp enable", amp_en, c != 3'h3);
    check("pll enable", pll_en, factor(c) != 0 || !dis);
    seed = lfsr(seed);
    pins <= seed[2:0];
    repeat (4) @(posedge clk_sys_in);
    check("held config", bits, c);
  endtask : start
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    int n, h, l, cnt, e;
    for (int c = 0; c < 8; c++) begin
      seed = lfsr(seed);
      start(c[2:0], seed[0]);
      if (factor(c[2:0]) != 0) begin
        cnt = 0;
        e = 8 * factor(c[2:0]);
        repeat (100) @(posedge clk_sys_in);
        for (int k = 0; k < 256; k++) begin
          @(posedge clk_sys_in);
          if (rise === 1'b1) cnt++;
        end
        check("pll rise count", (cnt >= e - 1 && cnt <= e + 1) ? e : cnt, e);
      end
      $display("config code %0d done", c);
    end
    hi <= 8'h03;
    lo <= 8'h05;
    start(3'h3, 1'b0);
    meas(h, l);
    check("direct high", h, 3);
    check("direct low", l, 5);
    $display("direct drive done");
    lo <= 8'h07;
    start(3'h1, 1'b1);
    meas(h, l);
    check("prescale high", h, 10);
    check("prescale low", l, 10);
    $display("prescaler done");
    hi <= 8'h04;
    lo <= 8'h04;
    start(3'h1, 1'b0);
    stop <= 1'b1;
    wait_for(2, 200, n);
    check("watchdog delay", n >= 56 && n <= 80, 1);
    check("fail with irq", fail, 1'b1);
    @(posedge clk_sys_in);
    check("irq one cycle", irq, 1'b0);
    stop <= 1'b0;
    repeat (50) @(posedge clk_sys_in);
    meas(h, l);
    check("pll tick phases", {h[7:0], l[7:0]}, 16'h0404);
    check("fail sticky", {fail, pll_en}, 2'h3);
    sw_reset_in <= 1'b1;
    @(posedge clk_sys_in);
    sw_reset_in <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
    check("fail cleared", {fail, bits}, 4'h1);
    $display("watchdog done");
    start(3'h3, 1'b1);
    stop <= 1'b1;
    cnt = 0;
    repeat (150) begin
      @(posedge clk_sys_in);
      if (irq !== 1'b0 || fail !== 1'b0) cnt++;
    end
    check("disabled watchdog", cnt, 0);
    check("pll off", pll_en, 1'b0);
    stop <= 1'b0;
    $display("watchdog disable done");
    results();
  end
endmodule : tb
